// ===== ccf_top.sv
// Purpose: Serial configuration loader and field holder of a clock manager
// Assumes: Pins are sampled on clk_sys at 40 MHz; PLL and deskew are analog
// Notes: Mode strap captured just after reset release
// How it works
// - Two ratio fields of 7 and 6 bits set the clock multiply/divide ratio.
// - A 2-bit range field selects the output frequency range.
// - Input type 0 routes the TTL reference, 1 routes the PECL reference.
// - Bypass bit 1 routes the reference straight to the outputs.
// - Deskew disable 1 turns adaptive deskew off.
// - Deskew disable 0 runs adaptive deskew once the fields are loaded.
// - Only the wide variant carries the deskew disable bit.
// - The chain is 18 bits on the narrow variant and 19 on the wide one.
// - In external-clock mode data is taken on the first rising edges.
// - Lock rises only after load, PLL lock and stable deskewed outputs.

`timescale 1ns/1ps

module ccf_top
    import ccf_pkg::*;
#(
    parameter bit WIDE_VARIANT = 1'b1,
    parameter int SETTLE_CYC = CCF_SETTLE_CYC
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic load_mode_strap,
    input wire logic strap_float,
    input wire logic cfg_clk,
    input wire logic config_serial_data,
    input wire logic rom_msb,
    input wire logic pll_locked,
    input wire logic deskew_done,
    output logic cfg_loaded,
    output ccf_fields_t fields,
    output logic ref_sel_pecl,
    output logic pll_bypass,
    output logic deskew_enable,
    output logic lock
);

    localparam logic [CCF_CNT_W-1:0] CHAIN_LEN = WIDE_VARIANT ?
        CCF_CNT_W'(CCF_CHAIN_LONG) : CCF_CNT_W'(CCF_CHAIN_SHORT);

    logic clk_s;
    logic data_s;
    logic float_s;
    logic strap_s;
    logic msb_s;
    logic clk_d;
    logic strap_taken;
    ccf_mode_t mode;
    logic [CCF_CHAIN_MAX-1:0] chain;
    logic [CCF_CNT_W-1:0] count;
    logic loading;
    logic [CCF_SETTLE_W-1:0] settle;
    logic [CCF_CHAIN_MAX-1:0] rom_word;
    logic [CCF_CHAIN_MAX-1:0] chain_aligned;
    ccf_fields_t next_fields;
    logic clk_rise;
    logic shift_now;
    logic last_bit;
    logic [CCF_ROM_SEL_W-1:0] rom_sel;
    logic settled;
    logic locked_s;
    logic deskew_s;
    logic all_good;
    logic load_now;
    logic awake;
    logic [CCF_WAKE_W-1:0] wake;
    logic [CCF_CHAIN_MAX-1:0] rom_narrow;
    logic [CCF_CHAIN_MAX-1:0] rom_wide;

    ccf_sync u_clk
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(cfg_clk),
        .sync_out(clk_s)
    );

    ccf_sync u_dat
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(config_serial_data),
        .sync_out(data_s)
    );

    ccf_sync u_flt
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(strap_float),
        .sync_out(float_s)
    );

    ccf_sync u_str
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(load_mode_strap),
        .sync_out(strap_s)
    );

    ccf_sync u_msb
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(rom_msb),
        .sync_out(msb_s)
    );

    ccf_sync u_lck
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(pll_locked),
        .sync_out(locked_s)
    );

    ccf_sync u_dsk
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(deskew_done),
        .sync_out(deskew_s)
    );

    assign clk_rise = clk_s && !clk_d;
    assign shift_now = loading && (mode != CCF_MODE_ROM) && clk_rise;
    assign last_bit = shift_now && (count == CHAIN_LEN - 5'h01);
    assign rom_sel = {msb_s, clk_s, data_s};

    // Narrow preset table in chain order with a trailing deskew bit
    always_comb
    begin
        case (rom_sel)
            3'h0: rom_narrow = {7'h00, 2'h1, 1'h1, 1'h1, 1'h0, 6'h00, 1'h0};
            3'h1: rom_narrow = {7'h02, 2'h2, 1'h1, 1'h1, 1'h0, 6'h05, 1'h0};
            3'h2: rom_narrow = {7'h05, 2'h1, 1'h1, 1'h1, 1'h0, 6'h02, 1'h0};
            3'h3: rom_narrow = {7'h00, 2'h1, 1'h0, 1'h1, 1'h0, 6'h00, 1'h0};
            3'h4: rom_narrow = {7'h00, 2'h1, 1'h0, 1'h0, 1'h0, 6'h00, 1'h0};
            3'h5: rom_narrow = {7'h02, 2'h2, 1'h0, 1'h0, 1'h0, 6'h05, 1'h0};
            3'h6: rom_narrow = {7'h05, 2'h1, 1'h0, 1'h0, 1'h0, 6'h02, 1'h0};
            default:
                rom_narrow = {7'h00, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00, 1'h0};
        endcase
    end

    // Wide presets sit one range step lower for the same ratios, except the default entry, which keeps range 0
    always_comb
    begin
        case (rom_sel)
            3'h0: rom_wide = {7'h00, 2'h0, 1'h1, 1'h1, 1'h0, 6'h00, 1'h0};
            3'h1: rom_wide = {7'h02, 2'h1, 1'h1, 1'h1, 1'h0, 6'h05, 1'h0};
            3'h2: rom_wide = {7'h05, 2'h0, 1'h1, 1'h1, 1'h0, 6'h02, 1'h0};
            3'h3: rom_wide = {7'h00, 2'h0, 1'h0, 1'h1, 1'h0, 6'h00, 1'h0};
            3'h4: rom_wide = {7'h00, 2'h0, 1'h0, 1'h0, 1'h0, 6'h00, 1'h0};
            3'h5: rom_wide = {7'h02, 2'h1, 1'h0, 1'h0, 1'h0, 6'h05, 1'h0};
            3'h6: rom_wide = {7'h05, 2'h0, 1'h0, 1'h0, 1'h0, 6'h02, 1'h0};
            default:
                rom_wide = {7'h00, 2'h0, 1'h0, 1'h0, 1'h1, 6'h00, 1'h0};
        endcase
    end

    assign rom_word = WIDE_VARIANT ? rom_wide : rom_narrow;

    assign awake = (wake == CCF_WAKE_W'(CCF_SYNC_LAT));

    // Synchronisers sit in reset, so straps are read once they settle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            wake <= '0;
        else if (!awake)
            wake <= wake + 3'h1;
    end

    // Short chain sits one bit lower; pad with zero deskew disable
    always_comb
    begin
        chain_aligned = WIDE_VARIANT ? {chain[CCF_CHAIN_MAX-2:0], data_s}
                                     : {chain[CCF_CHAIN_MAX-3:0], data_s, 1'h0};
        next_fields.ratio_field_a =
            chain_aligned[CCF_POS_RATIO_A+1 +: CCF_RATIO_A_W];
        next_fields.output_range_select =
            chain_aligned[CCF_POS_RANGE+1 +: CCF_RANGE_W];
        next_fields.cascade_reference_select =
            chain_aligned[CCF_POS_CASCADE+1];
        next_fields.input_type_select = chain_aligned[CCF_POS_INTYPE+1];
        next_fields.pll_bypass_bit = chain_aligned[CCF_POS_BYPASS+1];
        next_fields.ratio_field_b =
            chain_aligned[CCF_POS_RATIO_B+1 +: CCF_RATIO_B_W];
        next_fields.deskew_disable =
            WIDE_VARIANT ? chain_aligned[0] : 1'h0;
        if (mode == CCF_MODE_ROM)
        begin
            next_fields = rom_word;
            next_fields.deskew_disable = 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            clk_d <= 1'h0;
            strap_taken <= 1'h0;
            mode <= CCF_MODE_ROM;
            loading <= 1'h0;
        end
        else
        begin
            clk_d <= clk_s;
            if (!strap_taken && awake)
            begin
                strap_taken <= 1'h1;
                loading <= 1'h1;
                if (float_s)
                    mode <= CCF_MODE_MAIN;
                else if (strap_s)
                    mode <= CCF_MODE_AUX;
                else
                    mode <= CCF_MODE_ROM;
            end
            else if (loading && (mode == CCF_MODE_ROM || last_bit))
                loading <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            chain <= '0;
            count <= '0;
        end
        else if (shift_now)
        begin
            chain <= {chain[CCF_CHAIN_MAX-2:0], data_s};
            count <= count + 5'h01;
        end
    end

    assign load_now = strap_taken && loading && !cfg_loaded &&
        (mode == CCF_MODE_ROM || last_bit);

    // Fields load once per reset, after the whole chain, or one cycle after strap capture in ROM mode
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            fields <= '0;
            cfg_loaded <= 1'h0;
        end
        else if (load_now)
        begin
            fields <= next_fields;
            cfg_loaded <= 1'h1;
        end
    end

    assign ref_sel_pecl = (fields.input_type_select == CCF_IN_PECL);
    assign pll_bypass = cfg_loaded && fields.pll_bypass_bit;
    assign deskew_enable = cfg_loaded && !fields.deskew_disable;

    assign all_good = cfg_loaded && locked_s && deskew_s;
    assign settled = (settle == CCF_SETTLE_W'(SETTLE_CYC));

    // Settle count restarts whenever the PLL or deskew drops out
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            settle <= '0;
        else if (all_good && !settled)
            settle <= settle + 8'h01;
        else if (!(locked_s && deskew_s))
            settle <= '0;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            lock <= 1'h0;
        else
            lock <= all_good && settled;
    end

endmodule

// ===== ccf_pkg.sv
// Purpose: Shared constants and types for the clock configuration fields
// Assumes: One system clock, active-low asynchronous reset
// Notes: Chain order is ratio_a, range, cascade, input type, bypass, ratio_b,
//        then deskew disable on the wide variant

package ccf_pkg;

    localparam int CCF_RATIO_A_W = 7;
    localparam int CCF_RATIO_B_W = 6;
    localparam int CCF_RANGE_W = 2;
    localparam int CCF_CHAIN_SHORT = 18;
    localparam int CCF_CHAIN_LONG = 19;
    localparam int CCF_CHAIN_MAX = 19;
    localparam int CCF_CNT_W = 5;

    // Bit positions inside the shifted chain, first-shifted bit highest
    localparam int CCF_POS_RATIO_A = 11;
    localparam int CCF_POS_RANGE = 9;
    localparam int CCF_POS_CASCADE = 8;
    localparam int CCF_POS_INTYPE = 7;
    localparam int CCF_POS_BYPASS = 6;
    localparam int CCF_POS_RATIO_B = 0;

    // Input type select encodings
    localparam logic CCF_IN_TTL = 1'h0;
    localparam logic CCF_IN_PECL = 1'h1;

    // Three-bit ROM code width
    localparam int CCF_ROM_SEL_W = 3;

    // Cycles until a synchronised pin carries its real level after reset
    localparam int CCF_SYNC_LAT = 4;
    localparam int CCF_WAKE_W = 3;

    // Settling time before lock may be reported
    localparam int CCF_SETTLE_NS = 1000;
    localparam int CCF_CLK_NS = 25;
    localparam int CCF_SETTLE_CYC =
        (CCF_SETTLE_NS + CCF_CLK_NS - 1) / CCF_CLK_NS;
    localparam int CCF_SETTLE_W = 8;

    typedef enum logic [1:0]
    {
        CCF_MODE_ROM,
        CCF_MODE_AUX,
        CCF_MODE_MAIN
    } ccf_mode_t;

    typedef struct packed
    {
        logic [CCF_RATIO_A_W-1:0] ratio_field_a;
        logic [CCF_RANGE_W-1:0] output_range_select;
        logic cascade_reference_select;
        logic input_type_select;
        logic pll_bypass_bit;
        logic [CCF_RATIO_B_W-1:0] ratio_field_b;
        logic deskew_disable;
    } ccf_fields_t;

endpackage

// ===== ccf_sync.sv
// Purpose: Three-stage synchroniser with agreement-based change detect
// Assumes: Input is asynchronous to clk_sys
// Notes: First stage feeds only the second

`timescale 1ns/1ps

module ccf_sync
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);

    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
            sync_out <= 1'h0;
        end
        else
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                sync_out <= s3;
        end
    end

endmodule

// ===== ccf_monitor.sv
// Purpose: Port checker for ccf_top
// Assumes: One clk_sys domain, nrst active low
// Notes: Bound to ccf_top below

`timescale 1ns/1ps

module ccf_monitor
    import ccf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic pll_locked,
    input wire logic deskew_done,
    input wire logic cfg_loaded,
    input wire ccf_fields_t fields,
    input wire logic ref_sel_pecl,
    input wire logic pll_bypass,
    input wire logic deskew_enable,
    input wire logic lock
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_pecl; ref_sel_pecl == fields.input_type_select; endproperty
    a_pecl: assert property (p_pecl) else $error("bad ref select");
    property p_byp; pll_bypass == (cfg_loaded && fields.pll_bypass_bit);
    endproperty
    a_byp: assert property (p_byp) else $error("bad bypass");
    property p_dsk;
        deskew_enable == (cfg_loaded && !fields.deskew_disable);
    endproperty
    a_dsk: assert property (p_dsk) else $error("bad deskew");
    property p_lk; lock |-> cfg_loaded; endproperty
    a_lk: assert property (p_lk) else $error("lock before load");
    property p_drop; !pll_locked [*2] |-> ##4 !lock; endproperty
    a_drop: assert property (p_drop) else $error("lock held");
    property p_rise;
        $rose(lock) |-> $past(pll_locked, 2) && $past(deskew_done, 2);
    endproperty
    a_rise: assert property (p_rise) else $error("early lock");
    property p_hold; cfg_loaded |=> cfg_loaded && $stable(fields); endproperty
    a_hold: assert property (p_hold) else $error("fields moved");
    property p_pre; !cfg_loaded |-> fields == '0; endproperty
    a_pre: assert property (p_pre) else $error("partial load");
    c_load: cover property ($rose(cfg_loaded));
    c_lock: cover property ($rose(lock));
    c_byp: cover property (pll_bypass);
endmodule

bind ccf_top ccf_monitor mon (.clk_sys, .nrst, .pll_locked, .deskew_done,
    .cfg_loaded, .fields, .ref_sel_pecl, .pll_bypass, .deskew_enable, .lock);

// ===== ccf_source.sv
// Purpose: Externally clocked configuration source
// Assumes: Pins change 2 ns after clk_sys rising edges
// Notes: Clock stands low between frames; released data inverts

`timescale 1ns/1ps

module ccf_source
(
    input wire logic clk_sys,
    output logic cfg_clk,
    output logic config_serial_data
);
    localparam int HALF = 5;
    initial
    begin
        cfg_clk = 1'b0;
        config_serial_data = 1'b0;
    end
    task automatic sel(input logic c, input logic d);
        cfg_clk = c;
        config_serial_data = d;
    endtask
    task automatic send(input logic [18:0] w, input int n);
        for (int i = 18; i > 18 - n; i--)
        begin
            @(posedge clk_sys) #2;
            config_serial_data = w[i];
            cfg_clk = 1'b0;
            repeat (HALF) @(posedge clk_sys);
            #2 cfg_clk = 1'b1;
            repeat (HALF) @(posedge clk_sys);
        end
        #2 cfg_clk = 1'b0;
        config_serial_data = ~config_serial_data;
    endtask
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for ccf_top
// Assumes: Wide variant, settle count of 2
// Notes: Straps are set while reset is held, except strap_float, which is set just before reset

`timescale 1ns/1ps

module testbench
    import ccf_pkg::*;
;
    logic clk_sys, nrst = 1'b0, strap = 1'b0, rom_msb = 1'b0;
    logic pll_locked = 1'b0, deskew_done = 1'b0;
    logic flt = 1'b0;
    logic cfg_clk, config_serial_data, cfg_loaded;
    logic ref_sel_pecl, pll_bypass, deskew_enable, lock;
    ccf_fields_t fields;
    ccf_fields_t pat [2];
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;

    ccf_top #(.WIDE_VARIANT(1'b1), .SETTLE_CYC(2)) dut (.clk_sys, .nrst,
        .load_mode_strap(strap), .strap_float(flt), .cfg_clk,
        .config_serial_data, .rom_msb, .pll_locked, .deskew_done,
        .cfg_loaded, .fields, .ref_sel_pecl, .pll_bypass,
        .deskew_enable, .lock);
    ccf_source src (.clk_sys, .cfg_clk, .config_serial_data);

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_b(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: flag %b", $time, g);
        end
    endtask
    task automatic chk_f(input ccf_fields_t g, input ccf_fields_t e);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: fields %h", $time, g);
        end
    endtask
    task automatic rst(input logic m, r, c, d);
        @(posedge clk_sys) #2;
        nrst = 1'b0;
        strap = m;
        rom_msb = r;
        pll_locked = 1'b0;
        deskew_done = 1'b0;
        src.sel(c, d);
        repeat (10) @(posedge clk_sys);
        #2 nrst = 1'b1;
    endtask
    task automatic wait_load();
        for (int i = 0; i < 400 && cfg_loaded !== 1'b1; i++)
            @(posedge clk_sys);
        #2;
    endtask

    initial
    begin
        pat[0] = {7'h5a, 2'h2, 1'h1, 1'h1, 1'h0, 6'h2b, 1'h0};
        pat[1] = {7'h25, 2'h1, 1'h0, 1'h0, 1'h1, 6'h14, 1'h1};
        foreach (pat[k])
        begin
            flt = (k == 1); // Floating strap on the second pattern
            rst(1'b1, 1'b0, 1'b0, 1'b0);
            pll_locked = 1'b1;
            deskew_done = 1'b1;
            repeat (8) @(posedge clk_sys);
            #2 chk_b(lock, 1'b0);
            src.send(pat[k], 19);
            wait_load();
            chk_b(cfg_loaded, 1'b1);
            chk_f(fields, pat[k]);
            chk_b(ref_sel_pecl, pat[k].input_type_select);
            chk_b(pll_bypass, pat[k].pll_bypass_bit);
            chk_b(deskew_enable, !pat[k].deskew_disable);
            src.send(~pat[k], 3);
            chk_f(fields, pat[k]);
            chk_b(lock, 1'b1);
            pll_locked = 1'b0;
            repeat (5) @(posedge clk_sys);
            #2 chk_b(lock, 1'b0);
        end
        flt = 1'b0;
        rst(1'b0, 1'b1, 1'b1, 1'b1);
        wait_load();
        chk_b(fields.pll_bypass_bit, 1'b1);
        chk_b(fields.input_type_select, CCF_IN_TTL);
        rst(1'b0, 1'b0, 1'b0, 1'b1);
        wait_load();
        chk_f(fields, {7'h02, 2'h1, 1'h1, 1'h1, 1'h0, 6'h05, 1'h0});
        complete_run();
    end
endmodule
